// *** rtl/oam_exec.sv ***
`timescale 1ns/1ps
module oam_exec
  import oam_pkg::*;
(
  input  wire logic                        mclk,
  input  wire logic                        rst_b,
  input  wire logic                        instr_valid,
  input  wire logic [oam_pkg::INSTR_W-1:0] instr_word,
  input  wire logic [oam_pkg::DATA_W-1:0]  file_rdata,
  output logic      [oam_pkg::FADDR_W-1:0] file_addr,
  output logic                             file_rd,
  output logic      [oam_pkg::DATA_W-1:0]  file_wdata,
  output logic                             file_we,
  output logic      [oam_pkg::DATA_W-1:0]  acc,
  output logic                             zero_flag,
  output logic                             instr_done,
  output logic                             instr_illegal
);
  import oam_pkg::*;

  typedef enum logic [1:0] {
    OAM_OP_NONE,
    OAM_OP_OR_LIT,
    OAM_OP_LOAD_LIT,
    OAM_OP_FILE
  } oam_op_e;

  oam_phase_e               phase_q;
  oam_op_e                  op_q;
  logic                     or_sel_q;
  logic                     dest_q;
  logic [DATA_W-1:0]        lit_q;
  logic [DATA_W-1:0]        result_q;
  logic [DATA_W-1:0]        result_d;
  logic                     busy_q;
  oam_op_e                  op_d;
  logic                     or_sel_d;
  logic                     illegal_d;

  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    is_zero = (v == '0);
  endfunction

  // Field decoders; the literal class shares its top bits with other literal ops
  function automatic logic is_or_lit(input logic [INSTR_W-1:0] w);
    is_or_lit = (w[INSTR_W-1 -: 2] == CLASS_LIT) && (w[DATA_W +: 4] == OPC_OR_LIT);
  endfunction

  function automatic logic is_load_lit(input logic [INSTR_W-1:0] w);
    is_load_lit = (w[INSTR_W-1 -: 4] == OPC_LOAD_LIT);
  endfunction

  function automatic logic is_or_file(input logic [INSTR_W-1:0] w);
    is_or_file = (w[INSTR_W-1 -: 6] == OPC_OR_FILE);
  endfunction

  function automatic logic is_move_file(input logic [INSTR_W-1:0] w);
    is_move_file = (w[INSTR_W-1 -: 6] == OPC_MOVE_FILE);
  endfunction

  // Phase counter; an instruction is accepted only at Q1 so each takes four clocks
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      phase_q <= OAM_Q1;
    end else begin
      case (phase_q)
        OAM_Q1:  phase_q <= OAM_Q2;
        OAM_Q2:  phase_q <= OAM_Q3;
        OAM_Q3:  phase_q <= OAM_Q4;
        OAM_Q4:  phase_q <= OAM_Q1;
        default: phase_q <= OAM_Q1;
      endcase
    end
  end

  // Classify the word as presented; only the Q1 edge keeps the outcome
  always_comb begin
    op_d      = OAM_OP_NONE;
    or_sel_d  = 1'b0;
    illegal_d = 1'b0;
    if (instr_valid) begin
      if (is_or_lit(instr_word)) begin
        op_d = OAM_OP_OR_LIT;
      end else if (is_load_lit(instr_word)) begin
        op_d = OAM_OP_LOAD_LIT;
      end else if (is_or_file(instr_word)) begin
        op_d     = OAM_OP_FILE;
        or_sel_d = 1'b1;
      end else if (is_move_file(instr_word)) begin
        op_d = OAM_OP_FILE;
      end else begin
        // Unknown words leave acc and zero_flag unchanged and write no file; the flag tells the sequencer
        illegal_d = 1'b1;
      end
    end
  end

  // Q1 decode: operation held for the whole instruction cycle
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      op_q     <= OAM_OP_NONE;
      or_sel_q <= 1'b0;
    end else if (phase_q == OAM_Q1) begin
      op_q     <= op_d;
      or_sel_q <= or_sel_d;
    end
  end

  // Q1 operand capture; fields are latched for literal ops too, unused there
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      lit_q     <= '0;
      file_addr <= '0;
      dest_q    <= 1'b0;
    end else if (phase_q == OAM_Q1) begin
      lit_q     <= instr_word[DATA_W-1:0];
      file_addr <= instr_word[FADDR_W-1:0];
      dest_q    <= instr_word[DEST_BIT];
    end
  end

  // Garbled words outside Q1 are ignored since only this edge samples them
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      busy_q        <= 1'b0;
      instr_illegal <= 1'b0;
    end else if (phase_q == OAM_Q1) begin
      busy_q        <= instr_valid;
      instr_illegal <= illegal_d;
    end
  end

  // Q2 file read strobe, standing through Q3 while file_rdata is taken
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      file_rd <= 1'b0;
    end else begin
      file_rd <= (phase_q == OAM_Q2) && (op_q == OAM_OP_FILE);
    end
  end

  // Q3 process data
  // The accumulator is read before its Q4 write, so OR sees the old value
  always_comb begin
    case (op_q)
      OAM_OP_OR_LIT:   result_d = acc | lit_q;
      OAM_OP_LOAD_LIT: result_d = lit_q;
      OAM_OP_FILE:     result_d = or_sel_q ? (acc | file_rdata) : file_rdata;
      default:         result_d = acc;
    endcase
  end

  // Result held so the Q4 write does not depend on file_rdata still standing
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      result_q <= '0;
    end else if (phase_q == OAM_Q3) begin
      result_q <= result_d;
    end
  end

  // Q4 write to destination
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      acc <= ACC_RESET;
    end else if (phase_q == OAM_Q4) begin
      case (op_q)
        OAM_OP_OR_LIT:   acc <= result_q;
        OAM_OP_LOAD_LIT: acc <= result_q;
        OAM_OP_FILE: begin
          if (!dest_q) begin
            acc <= result_q;
          end
        end
        default:         acc <= acc;
      endcase
    end
  end

  // Write strobe is one clock wide, in Q4 only
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      file_we <= 1'b0;
    end else begin
      file_we <= (phase_q == OAM_Q3) && (op_q == OAM_OP_FILE) && dest_q;
    end
  end

  // Data comes with the strobe and holds until the next instruction's Q3
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      file_wdata <= '0;
    end else if (phase_q == OAM_Q3) begin
      file_wdata <= result_d;
    end
  end

  // Load-literal leaves the zero flag alone
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      zero_flag <= ZERO_RESET;
    end else if (phase_q == OAM_Q4) begin
      if (op_q == OAM_OP_OR_LIT || op_q == OAM_OP_FILE) begin
        zero_flag <= is_zero(result_q);
      end
    end
  end

  // Every accepted word completes, illegal ones too, so the cadence never breaks
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      instr_done <= 1'b0;
    end else begin
      instr_done <= (phase_q == OAM_Q4) && busy_q;
    end
  end
endmodule

// *** include/oam_pkg.sv ***
package oam_pkg;
  // Instruction word layout
  localparam int INSTR_W   = 14;
  localparam int DATA_W    = 8;
  localparam int FADDR_W   = 7;
  localparam int DEST_BIT  = 7;
  // Opcode fields
  localparam logic [3:0] OPC_OR_LIT    = 4'h8;      // 11 1000 kkkk kkkk
  localparam logic [3:0] OPC_LOAD_LIT  = 4'hC;      // 11 00xx kkkk kkkk
  localparam logic [5:0] OPC_OR_FILE   = 6'h04;     // 00 0100 dfff ffff
  localparam logic [5:0] OPC_MOVE_FILE = 6'h08;     // 00 1000 dfff ffff
  localparam logic [1:0] CLASS_LIT     = 2'h3;
  localparam logic [1:0] CLASS_FILE    = 2'h0;
  // Reset values
  localparam logic [7:0] ACC_RESET     = 8'h00;
  localparam logic       ZERO_RESET    = 1'b0;
  // Quarter phases of one instruction cycle
  typedef enum logic [1:0] {
    OAM_Q1,
    OAM_Q2,
    OAM_Q3,
    OAM_Q4
  } oam_phase_e;
endpackage

// *** tb/oam_exec_asserts.sv ***
`timescale 1ns/1ps
module oam_exec_chk (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        instr_valid,
  input wire logic [13:0] instr_word,
  input wire logic [7:0]  file_rdata,
  input wire logic [7:0]  acc,
  input wire logic        zero_flag,
  input wire logic        file_we,
  input wire logic        instr_done,
  input wire logic        instr_illegal
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic [1:0] ph_q;
  always_ff @(posedge mclk) ph_q <= rst_b ? ph_q + 2'h1 : 2'h0;
  wire q1 = instr_valid && ph_q == 2'h0;
  wire lit = q1 && instr_word[13:8] == 6'h38;
  wire ld = q1 && instr_word[13:10] == 4'hC;
  wire fil = q1 && (instr_word[13:8] == 6'h04 || instr_word[13:8] == 6'h08);
  property p_or_lit; lit |-> ##4 acc == ($past(acc, 4) | $past(instr_word[7:0], 4)); endproperty
  a_or_lit: assert property (p_or_lit) else $error("or literal wrong");
  property p_or_zero; lit |-> ##4 zero_flag == (acc == 8'h00); endproperty
  a_or_zero: assert property (p_or_zero) else $error("or literal zero wrong");
  property p_decode; ld == 1'b0 && lit == 1'b0 && q1 && instr_word[13:12] == 2'h3 |=> instr_illegal; endproperty
  a_decode: assert property (p_decode) else $error("bad literal opcode taken");
  property p_move_acc; fil && instr_word[11:7] == 5'h10 |-> ##4 acc == $past(file_rdata, 2); endproperty
  a_move_acc: assert property (p_move_acc) else $error("move to acc wrong");
  property p_dest; fil |-> ##3 file_we == $past(instr_word[7], 3); endproperty
  a_dest: assert property (p_dest) else $error("destination wrong");
  property p_file_zero; fil && !instr_word[7] |-> ##4 zero_flag == (acc == 8'h00); endproperty
  a_file_zero: assert property (p_file_zero) else $error("file zero wrong");
  property p_load; ld |-> ##4 acc == $past(instr_word[7:0], 4) && zero_flag == $past(zero_flag, 4); endproperty
  a_load: assert property (p_load) else $error("load literal wrong");
  property p_done; q1 |-> ##4 instr_done; endproperty
  a_done: assert property (p_done) else $error("done missing");
endmodule
bind oam_exec oam_exec_chk u_chk (.mclk, .rst_b, .instr_valid, .instr_word, .file_rdata, .acc,
  .zero_flag, .file_we, .instr_done, .instr_illegal);

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic        mclk = 1'b0, rst_b = 1'b0, instr_valid = 1'b0;
  logic [13:0] instr_word = 14'h0000;
  logic [7:0]  file_rdata = 8'h00, file_wdata, acc;
  logic        file_we, zero_flag;
  logic [6:0]  file_addr;
  logic        file_rd;
  int          fails = 0, checks = 0;
  oam_exec DUT (.mclk(mclk), .rst_b(rst_b), .instr_valid(instr_valid), .instr_word(instr_word),
    .file_rdata(file_rdata), .file_addr(file_addr), .file_rd(file_rd),
    .file_wdata(file_wdata), .file_we(file_we),
    .acc(acc), .zero_flag(zero_flag), .instr_done(), .instr_illegal());
  initial forever #5 mclk = ~mclk;
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) fails++;
    if (got !== exp) $display("unexpected at %0t got %h exp %h", $time, got, exp);
  endtask
  // Word stays valid but garbled outside Q1, so a sloppy decoder would latch it
  task automatic run(input logic [13:0] w, input logic [7:0] rd, input logic [9:0] exp);
    logic we_seen;
    instr_valid = 1'b1;
    instr_word = w;
    file_rdata = rd;
    @(posedge mclk);
    #1 instr_word = 14'h38FF;
    chk({3'h0, file_addr}, {3'h0, w[6:0]});
    @(posedge mclk);
    #1 chk({9'h0, file_rd}, {9'h0, w[13:12] == 2'h0});
    @(posedge mclk);
    // The write strobe stands only in Q4, one clock before acc settles
    #1 we_seen = file_we;
    @(posedge mclk);
    #1 chk({we_seen, zero_flag, acc}, exp);
    chk({9'h0, file_we}, 10'h000);
  endtask
  task automatic t_lit;
    run(14'h309A, 8'h00, 10'h09A);
    run(14'h3835, 8'h00, 10'h0BF);
    run(14'h3300, 8'h00, 10'h000);
    run(14'h3800, 8'h00, 10'h100);
    run(14'h3155, 8'h00, 10'h155);
    run(14'h3900, 8'h00, 10'h155);
  endtask
  task automatic t_file;
    run(14'h0404, 8'h13, 10'h057);
    run(14'h0484, 8'h80, 10'h257);
    chk({2'h0, file_wdata}, 10'h0D7);
    run(14'h0804, 8'h00, 10'h100);
    run(14'h0884, 8'h77, 10'h200);
    chk({2'h0, file_wdata}, 10'h077);
    run(14'h0404, 8'h00, 10'h100);
  endtask
  task automatic finish_test;
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    #1 rst_b = 1'b1;
    t_lit();
    t_file();
    finish_test();
  end
endmodule
